// ===== lo_divider_pkg.sv
// Constants shared by the local oscillator divider front end.
package lo_divider_pkg;

  // ****************************************************************
  // Register map (byte addresses on the APB side)
  // ****************************************************************
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] IFCNT_OFFSET  = 12'h008;

  // ****************************************************************
  // Control word layout (serial frame and CTRL register alike)
  // ****************************************************************
  localparam int          FRAME_BITS     = 24;
  localparam int          DIVISOR_LSB    = 0;
  localparam int          DIVISOR_W      = 16;
  localparam int          BAND_SEL_POS   = 16;
  localparam int          SWALLOW_POS    = 17;
  localparam int          OUT_SEL_LSB    = 18;
  localparam int          OUT_SEL_W      = 3;
  localparam logic [23:0] CTRL_RESET     = 24'h000110;

  // ****************************************************************
  // Divisor ranges
  // ****************************************************************
  localparam logic [15:0] SWALLOW_MIN    = 16'h0110;
  localparam logic [15:0] DIRECT_MIN     = 16'h0004;
  localparam int          DIRECT_W       = 12;

  // ****************************************************************
  // Serial output content codes
  // ****************************************************************
  localparam logic [2:0]  OUT_SEL_NONE   = 3'h0;
  localparam logic [2:0]  OUT_SEL_IFCNT  = 3'h1;
  localparam logic [2:0]  OUT_SEL_CTRL   = 3'h2;
  localparam int          IF_COUNT_W     = 20;

  typedef enum logic [0:0] {
    LINK_IDLE  = 1'b0,
    LINK_FRAME = 1'b1
  } link_state_type;

endpackage

// ===== lo_divider.sv
// Local oscillator input selection, division paths and serial control port.
`timescale 1ns/1ps

module lo_divider
  import lo_divider_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic                  chip_enable_i,
  input  wire logic                  serial_strobe_i,
  input  wire logic                  serial_in_i,
  output logic                       serial_out_o,
  output logic                       serial_out_en_o,
  input  wire logic                  high_band_osc_input_i,
  input  wire logic                  low_band_osc_input_i,
  input  wire logic [IF_COUNT_W-1:0] if_count_i,
  output logic                       div_pulse_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Divisors below the path minimum are raised to it, so a bad load
  // can never make the counter wrap through zero.
  function automatic logic [15:0] eff_divisor(input logic [23:0] ctrl);
    logic [15:0] div;
    logic [15:0] low12;
    div   = ctrl[DIVISOR_LSB +: DIVISOR_W];
    low12 = {4'h0, div[DIRECT_W-1:0]};
    if (ctrl[BAND_SEL_POS] || ctrl[SWALLOW_POS]) begin
      eff_divisor = (div < SWALLOW_MIN) ? SWALLOW_MIN : div;
    end else begin
      eff_divisor = (low12 < DIRECT_MIN) ? DIRECT_MIN : low12;
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] ce_sync;
  logic [1:0] strobe_sync;
  logic [1:0] din_sync;
  logic [1:0] hi_sync;
  logic [1:0] lo_sync;
  logic       ce_prev;
  logic       strobe_prev;
  logic       hi_prev;
  logic       lo_prev;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ce_sync     <= 2'h0;
      strobe_sync <= 2'h0;
      din_sync    <= 2'h0;
      hi_sync     <= 2'h0;
      lo_sync     <= 2'h0;
      ce_prev     <= 1'b0;
      strobe_prev <= 1'b0;
      hi_prev     <= 1'b0;
      lo_prev     <= 1'b0;
    end else begin
      ce_sync     <= {ce_sync[0], chip_enable_i};
      strobe_sync <= {strobe_sync[0], serial_strobe_i};
      din_sync    <= {din_sync[0], serial_in_i};
      hi_sync     <= {hi_sync[0], high_band_osc_input_i};
      lo_sync     <= {lo_sync[0], low_band_osc_input_i};
      ce_prev     <= ce_sync[1];
      strobe_prev <= strobe_sync[1];
      hi_prev     <= hi_sync[1];
      lo_prev     <= lo_sync[1];
    end
  end

  logic ce_rise;
  logic ce_fall;
  logic strobe_rise;
  logic strobe_fall;
  logic hi_edge;
  logic lo_edge;

  assign ce_rise     = ce_sync[1] & ~ce_prev;
  assign ce_fall     = ~ce_sync[1] & ce_prev;
  assign strobe_rise = strobe_sync[1] & ~strobe_prev;
  assign strobe_fall = ~strobe_sync[1] & strobe_prev;
  assign hi_edge     = hi_sync[1] & ~hi_prev;
  assign lo_edge     = lo_sync[1] & ~lo_prev;

  // ****************************************************************
  // Serial control port
  // ****************************************************************
  link_state_type       link_state;
  link_state_type       next_link_state;
  logic [23:0]          ctrl;
  logic [23:0]          next_ctrl;
  logic [23:0]          shift_in;
  logic [23:0]          next_shift_in;
  logic [5:0]           bit_count;
  logic [5:0]           next_bit_count;
  logic [23:0]          shift_out;
  logic [23:0]          next_shift_out;
  logic                 next_serial_out;
  logic                 next_serial_out_en;
  logic [15:0]          frame_count;
  logic [15:0]          next_frame_count;
  logic                 apb_ctrl_write;
  logic [OUT_SEL_W-1:0] out_sel;

  assign out_sel = ctrl[OUT_SEL_LSB +: OUT_SEL_W];

  always_comb begin
    next_link_state    = link_state;
    next_ctrl          = ctrl;
    next_shift_in      = shift_in;
    next_bit_count     = bit_count;
    next_shift_out     = shift_out;
    next_serial_out    = serial_out_o;
    next_serial_out_en = serial_out_en_o;
    next_frame_count   = frame_count;
    if (apb_ctrl_write) begin
      next_ctrl = pwdata_i[FRAME_BITS-1:0];
    end
    case (link_state)
      LINK_IDLE: begin
        next_serial_out_en = 1'b0;
        if (ce_rise) begin
          next_link_state = LINK_FRAME;
          next_bit_count  = 6'h00;
          case (out_sel)
            OUT_SEL_IFCNT: next_shift_out = {if_count_i, 4'h0};
            OUT_SEL_CTRL:  next_shift_out = ctrl;
            default:       next_shift_out = 24'hFFFFFF;
          endcase
          next_serial_out    = next_shift_out[FRAME_BITS-1];
          next_serial_out_en = (out_sel != OUT_SEL_NONE);
        end
      end
      LINK_FRAME: begin
        if (strobe_rise && bit_count != 6'(FRAME_BITS)) begin
          next_shift_in  = {shift_in[FRAME_BITS-2:0], din_sync[1]};
          next_bit_count = bit_count + 6'h01;
        end
        if (strobe_fall) begin
          next_shift_out  = {shift_out[FRAME_BITS-2:0], 1'b1};
          next_serial_out = next_shift_out[FRAME_BITS-1];
        end
        if (ce_fall) begin
          next_link_state    = LINK_IDLE;
          next_serial_out    = 1'b1;
          next_serial_out_en = 1'b0;
          if (bit_count == 6'(FRAME_BITS)) begin
            // A serial load beats a same-cycle bus write to the control word.
            next_ctrl        = shift_in;
            next_frame_count = frame_count + 16'h0001;
          end
        end
      end
      default: begin
        next_link_state = LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      link_state      <= LINK_IDLE;
      ctrl            <= CTRL_RESET;
      shift_in        <= 24'h000000;
      bit_count       <= 6'h00;
      shift_out       <= 24'hFFFFFF;
      serial_out_o    <= 1'b1;
      serial_out_en_o <= 1'b0;
      frame_count     <= 16'h0000;
    end else begin
      link_state      <= next_link_state;
      ctrl            <= next_ctrl;
      shift_in        <= next_shift_in;
      bit_count       <= next_bit_count;
      shift_out       <= next_shift_out;
      serial_out_o    <= next_serial_out;
      serial_out_en_o <= next_serial_out_en;
      frame_count     <= next_frame_count;
    end
  end

  // ****************************************************************
  // Input selection, prescaler and programmable divider
  // ****************************************************************
  logic        prescale;
  logic        next_prescale;
  logic [15:0] div_count;
  logic [15:0] next_div_count;
  logic        next_div_pulse;
  logic [15:0] pulse_count;
  logic [15:0] next_pulse_count;
  logic        count_edge;
  logic [15:0] divisor;

  assign divisor = eff_divisor(ctrl);

  always_comb begin
    next_prescale    = prescale;
    next_div_count   = div_count;
    next_div_pulse   = 1'b0;
    next_pulse_count = pulse_count;
    count_edge       = 1'b0;
    if (ctrl[BAND_SEL_POS]) begin
      // The prescaler passes every second high-band edge, doubling N.
      next_prescale = prescale ^ hi_edge;
      count_edge    = hi_edge & prescale;
    end else begin
      next_prescale = 1'b0;
      count_edge    = lo_edge;
    end
    if (count_edge) begin
      if (div_count >= divisor - 16'h0001) begin
        next_div_count   = 16'h0000;
        next_div_pulse   = 1'b1;
        next_pulse_count = pulse_count + 16'h0001;
      end else begin
        next_div_count = div_count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prescale    <= 1'b0;
      div_count   <= 16'h0000;
      div_pulse_o <= 1'b0;
      pulse_count <= 16'h0000;
    end else begin
      prescale    <= next_prescale;
      div_count   <= next_div_count;
      div_pulse_o <= next_div_pulse;
      pulse_count <= next_pulse_count;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic        access;
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;
  logic        addr_ok;

  // One wait state: pready rises at the first access-phase edge and is seen at the second.
  assign access         = psel_i & penable_i & ~pready_o;
  assign addr_ok        = (paddr_i == CTRL_OFFSET)
                        | (paddr_i == STATUS_OFFSET)
                        | (paddr_i == IFCNT_OFFSET);
  // A write lands at the edge where the master sees pready high, not before.
  assign apb_ctrl_write = psel_i & penable_i & pready_o & pwrite_i
                        & (paddr_i == CTRL_OFFSET);

  always_comb begin
    next_pready  = access;
    next_pslverr = access & ~addr_ok;
    next_prdata  = 32'h00000000;
    if (access && !pwrite_i) begin
      case (paddr_i)
        CTRL_OFFSET:   next_prdata = {8'h00, ctrl};
        STATUS_OFFSET: next_prdata = {pulse_count, frame_count};
        IFCNT_OFFSET:  next_prdata = {12'h000, if_count_i};
        default:       next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= next_pready;
      pslverr_o <= next_pslverr;
      prdata_o  <= next_prdata;
    end
  end

endmodule

// ===== lo_divider_sva.sv
// Concurrent checks on the ports of the divider front end.
`timescale 1ns/1ps
module lo_divider_sva
  import lo_divider_pkg::*;
(
  input wire logic                  clk_sys_i,
  input wire logic                  rst_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic                  pwrite_i,
  input wire logic [11:0]           paddr_i,
  input wire logic [31:0]           prdata_o,
  input wire logic                  pready_o,
  input wire logic                  pslverr_o,
  input wire logic                  chip_enable_i,
  input wire logic                  serial_out_o,
  input wire logic                  serial_out_en_o,
  input wire logic                  high_band_osc_input_i,
  input wire logic                  low_band_osc_input_i,
  input wire logic [IF_COUNT_W-1:0] if_count_i,
  input wire logic                  div_pulse_o
);
  logic acc;
  assign acc = psel_i && penable_i && !pready_o;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  ready_ans_a: assert property (acc |=> pready_o)
    else $error("Access got no ready.");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("Ready stood too long.");
  unmapped_err_a: assert property (acc && paddr_i > IFCNT_OFFSET |=>
    pslverr_o && prdata_o == 32'h0)
    else $error("Unmapped access not refused.");
  ifcnt_read_a: assert property (acc && !pwrite_i &&
    paddr_i == IFCNT_OFFSET |=>
    !pslverr_o && prdata_o == {12'h000, $past(if_count_i)})
    else $error("IF count read wrong.");
  idle_data_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("Read data outside answer.");
  out_idle_a: assert property (!chip_enable_i [*5] |->
    serial_out_o && !serial_out_en_o)
    else $error("Serial output active outside frame.");
  en_frame_a: assert property (serial_out_en_o |-> chip_enable_i ||
    $past(chip_enable_i) || $past(chip_enable_i, 2) ||
    $past(chip_enable_i, 3) || $past(chip_enable_i, 4))
    else $error("Serial drive without chip enable.");
  pulse_gap_a: assert property (div_pulse_o |=> !div_pulse_o)
    else $error("Divider pulse too long.");
  quiet_a: assert property ($stable(high_band_osc_input_i) &&
    $stable(low_band_osc_input_i) [*8] |=> !div_pulse_o)
    else $error("Divider pulse without input edges.");

  cover property (pready_o && pslverr_o);
  cover property (div_pulse_o);
  cover property ($rose(serial_out_en_o));
endmodule

bind lo_divider lo_divider_sva u_sva (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .chip_enable_i(chip_enable_i), .serial_out_o(serial_out_o),
  .serial_out_en_o(serial_out_en_o),
  .high_band_osc_input_i(high_band_osc_input_i),
  .low_band_osc_input_i(low_band_osc_input_i),
  .if_count_i(if_count_i), .div_pulse_o(div_pulse_o));

// ===== lo_ctl_model.sv
// Behavioural system controller driving the serial control port.
`timescale 1ns/1ps
module lo_ctl_model (
  input  wire logic clk_i,
  input  wire logic data_i,
  output logic      chip_enable_o,
  output logic      strobe_o,
  output logic      data_o
);
  logic [23:0] rx = 24'h000000;
  initial begin
    chip_enable_o = 1'b0;
    strobe_o = 1'b0;
    data_o = 1'b0;
  end
  // Strobe is 4 clocks low and 4 high, 400 ns at the 50 ns system clock.
  task automatic frame(input logic [23:0] word, input int nbits);
    @(posedge clk_i);
    chip_enable_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < nbits; i++) begin
      data_o <= word[23 - i];
      repeat (4) @(posedge clk_i);
      strobe_o <= 1'b1;
      rx <= {rx[22:0], data_i};
      repeat (4) @(posedge clk_i);
      strobe_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    chip_enable_o <= 1'b0;
    // The released line flips so that no stale bit can pass for data.
    data_o <= ~data_o;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// ===== lo_divider_tb.sv
// Self-checking testbench for the local oscillator divider front end.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  n_fail++; $display("BAD %0t got %0h exp %0h", $time, got, exp); end end
module lo_divider_tb import lo_divider_pkg::*;;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ce;
  logic        strobe;
  logic        sdi;
  logic        sdo;
  logic        sdo_en;
  logic        hb = 1'b0;
  logic        lb = 1'b0;
  logic        osc_on = 1'b0;
  logic        div_pulse;
  logic [19:0] if_count = 20'hA5C3E;
  int          cyc = 0;
  int          en_hits = 0;
  int          checks = 0;
  int          n_fail = 0;

  always #25 clk_sys_i = ~clk_sys_i;
  // High band runs at a period of 4 clocks, low band at 6.
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    hb <= osc_on && (cyc % 4 < 2);
    lb <= osc_on && (cyc % 6 < 3);
    en_hits <= en_hits + int'(sdo_en === 1'b1);
  end

  lo_divider dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .chip_enable_i(ce), .serial_strobe_i(strobe),
    .serial_in_i(sdi), .serial_out_o(sdo), .serial_out_en_o(sdo_en),
    .high_band_osc_input_i(hb), .low_band_osc_input_i(lb),
    .if_count_i(if_count), .div_pulse_o(div_pulse));
  lo_ctl_model ctl (.clk_i(clk_sys_i), .data_i(sdo), .chip_enable_o(ce),
    .strobe_o(strobe), .data_o(sdi));

  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    for (int k = 0; k <= 50; k++) begin
      @(posedge clk_sys_i);
      if (pready === 1'b1) break;
      if (k == 50) begin
        n_fail++;
        end_of_test();
      end
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_pulse(output int t);
    for (int k = 0; k <= 30000; k++) begin
      @(posedge clk_sys_i);
      if (div_pulse === 1'b1) begin
        t = cyc;
        return;
      end
    end
    n_fail++;
    end_of_test();
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    apb(1'b0, CTRL_OFFSET, 32'h0, q, e);
    `CHK(q, {8'h00, CTRL_RESET})
    apb(1'b0, IFCNT_OFFSET, 32'h0, q, e);
    `CHK(q, {12'h000, if_count})
    apb(1'b1, 12'h00C, 32'h00001234, q, e);
    `CHK(e, 1'b1)
    apb(1'b0, 12'h00C, 32'h0, q, e);
    `CHK({e, q}, 33'h100000000)
    apb(1'b1, CTRL_OFFSET, 32'h001CABCD, q, e);
    apb(1'b0, CTRL_OFFSET, 32'h0, q, e);
    `CHK(q, 32'h001CABCD)
    $display("test regs done");
  endtask

  task automatic t_load;
    logic [31:0] q;
    logic        e;
    ctl.frame(24'h035678, 24);
    apb(1'b0, CTRL_OFFSET, 32'h0, q, e);
    `CHK(q, 32'h00035678)
    ctl.frame(24'h000222, 23);
    apb(1'b0, CTRL_OFFSET, 32'h0, q, e);
    `CHK(q, 32'h00035678)
    apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
    `CHK(q, 32'h00000001)
    $display("test serial load done");
  endtask

  task automatic t_out(input logic [23:0] w, input logic [23:0] x,
    input logic en);
    logic [31:0] q;
    logic        e;
    int          n0;
    apb(1'b1, CTRL_OFFSET, {8'h00, w}, q, e);
    n0 = en_hits;
    ctl.frame(w, 24);
    `CHK(en_hits != n0, en)
    if (en) `CHK(ctl.rx, x)
  endtask

  task automatic t_div(input logic [23:0] w, input int per);
    logic [31:0] q;
    logic        e;
    int          t0;
    int          t1;
    apb(1'b1, CTRL_OFFSET, {8'h00, w}, q, e);
    wait_pulse(t0);
    wait_pulse(t0);
    wait_pulse(t1);
    `CHK(t1 - t0, per)
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    t_regs();
    t_load();
    t_out(24'h080123, 24'h080123, 1'b1);
    t_out(24'h040123, {if_count, 4'h0}, 1'b1);
    t_out(24'h000123, 24'h000000, 1'b0);
    $display("test serial output done");
    osc_on <= 1'b1;
    t_div(24'h010110, 2 * 272 * 4);
    t_div(24'h02012C, 300 * 6);
    t_div(24'h001005, 5 * 6);
    t_div(24'h00F004, 4 * 6);
    $display("test divider done");
    end_of_test();
  end
endmodule
